/* rtl/epc_pkg.sv */
package epc_pkg;

    // ------------------------------------------------------------
    // widths and register offsets
    // ------------------------------------------------------------
    localparam int unsigned EPC_CNT_W     = 24;
    localparam int unsigned EPC_WRAP_W    = 16;
    localparam int unsigned EPC_ADDR_W    = 8;
    localparam int unsigned EPC_DIV_W     = 3;
    localparam int unsigned EPC_DIVCNT_W  = 7;

    localparam logic [7:0] EPC_OFF_CTRL   = 8'h00;
    localparam logic [7:0] EPC_OFF_WRAP   = 8'h04;
    localparam logic [7:0] EPC_OFF_CMP    = 8'h08;
    localparam logic [7:0] EPC_OFF_CNT    = 8'h0c;
    localparam logic [7:0] EPC_OFF_CAP    = 8'h10;

    // ------------------------------------------------------------
    // control register field positions
    // ------------------------------------------------------------
    localparam int unsigned EPC_B_RUN     = 0;
    localparam int unsigned EPC_B_INTERRUPT_ENABLE   = 1;
    localparam int unsigned EPC_B_COMPARE_ENABLE   = 2;
    localparam int unsigned EPC_B_ZEN     = 3;
    localparam int unsigned EPC_B_ZSEL    = 4;
    localparam int unsigned EPC_B_P3      = 5;
    localparam int unsigned EPC_B_MODE    = 6;
    localparam int unsigned EPC_B_CLR     = 8;
    localparam int unsigned EPC_B_SCAP    = 9;
    localparam int unsigned EPC_B_DIV     = 12;
    localparam int unsigned EPC_B_DIR     = 16;

    // ------------------------------------------------------------
    // reset values and counter limits
    // ------------------------------------------------------------
    localparam logic [15:0] EPC_RST_WRAP  = 16'h0000;
    localparam logic [23:0] EPC_RST_CMP   = 24'h000000;
    localparam logic [23:0] EPC_RST_CNT   = 24'h000000;
    localparam logic [23:0] EPC_MAX24     = 24'hffffff;
    localparam logic [23:0] EPC_MAX16     = 24'h00ffff;

    typedef enum logic [1:0] {
        EPC_MODE_ENC = 2'h0,
        EPC_MODE_SEV = 2'h1,
        EPC_MODE_STM = 2'h2,
        EPC_MODE_TMR = 2'h3
    } epc_mode_e;

    typedef struct packed {
        logic                 run_enable;
        logic                 interrupt_enable;
        logic                 compare_enable;
        logic                 z_trigger_enable;
        logic                 z_edge_select;
        logic                 three_phase_select;
        epc_mode_e            mode;
        logic [EPC_DIV_W-1:0] pulse_divider;
    } epc_ctrl_s;

    localparam epc_ctrl_s EPC_RST_CTRL = '{
        run_enable:         1'b0,
        interrupt_enable:   1'b0,
        compare_enable:     1'b0,
        z_trigger_enable:   1'b0,
        z_edge_select:      1'b0,
        three_phase_select: 1'b0,
        mode:               EPC_MODE_ENC,
        pulse_divider:      3'h0
    };

    typedef struct packed {
        logic event_pulse;
        logic abnormal_time;
        logic timer_compare;
        logic capture;
    } epc_irq_s;

endpackage

/* rtl/epc_top.sv */
// Summary of operation
// R1 - timer mode: z input triggers only when enabled
// R2 - timer z edge clear, edge chosen by select
// R3 - timer counter wraps to zero after max
// R4 - soft clear zeroes counter in every mode
// R5 - timer z trigger captures counter value
// R6 - soft capture copies counter any time
// R7 - direction flag high after clockwise step, low after counter-clockwise step or while run low
// R8 - compare match raises interrupt when enabled
// R9 - captured value kept, cleared only by reset
// R10 - encoder mode: wrap limit, z clear, reload
// R11 - event mode: sixteen bit wrap and reload
// R12 - sensor timer: up count, cleared per pulse
// R13 - timer clears on max, compare, z trigger
// R14 - run low holds counter, resumes later
// R15 - four interrupt sources are provided
// R16 - interrupt enable gates all interrupt sources
// R17 - sensor timer pulse captures counter value
// R18 - timer z edge captures as external trigger
// R19 - software sets three phase for three inputs
// R20 - one shared 24 bit up/down counter
// R21 - each interrupt is a one cycle pulse
`timescale 1ns/1ps
module epc_top
(
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [epc_pkg::EPC_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                     pwdata,
    output logic      [31:0]                     prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    input  wire logic                            phase_a,
    input  wire logic                            phase_b,
    input  wire logic                            phase_z,
    output epc_pkg::epc_irq_s                    irq,
    output logic                                 direction_flag,
    output logic                                 quadrature_count_pulse,
    output logic                                 divided_pulse
);
    import epc_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] quad_idx(input logic [1:0] ab);
        logic [2:0] r;
        r = 3'h0;
        unique case (ab)
            2'b00: r = 3'h0;
            2'b10: r = 3'h1;
            2'b11: r = 3'h2;
            2'b01: r = 3'h3;
        endcase
        return r;
    endfunction

    function automatic logic [2:0] hall_idx(input logic [2:0] uvw);
        logic [2:0] r;
        r = 3'h7;
        case (uvw)
            3'b100:  r = 3'h0;
            3'b110:  r = 3'h1;
            3'b010:  r = 3'h2;
            3'b011:  r = 3'h3;
            3'b001:  r = 3'h4;
            3'b101:  r = 3'h5;
            default: r = 3'h7;
        endcase
        return r;
    endfunction

    function automatic logic [2:0] step_fwd(input logic [2:0] i,
                                            input logic       six);
        logic [2:0] top;
        top = six ? 3'h5 : 3'h3;
        return (i == top) ? 3'h0 : 3'(i + 3'h1);
    endfunction

    function automatic logic [2:0] step_back(input logic [2:0] i,
                                             input logic       six);
        logic [2:0] top;
        top = six ? 3'h5 : 3'h3;
        return (i == 3'h0) ? top : 3'(i - 3'h1);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    epc_ctrl_s                 ctrl_q;
    logic [EPC_WRAP_W-1:0]     wrap_q;
    logic [EPC_CNT_W-1:0]      cmp_q;
    logic [EPC_CNT_W-1:0]      cnt_q;
    logic [EPC_CNT_W-1:0]      cnt_d;
    logic [EPC_CNT_W-1:0]      cap_q;
    logic [2:0]                sync1_q;
    logic [2:0]                sync2_q;
    logic [2:0]                prev_q;
    logic                      dir_q;
    logic                      dir_d;
    logic                      match_q;
    logic [EPC_DIVCNT_W-1:0]   div_cnt_q;
    logic [EPC_DIVCNT_W-1:0]   div_cnt_d;
    logic [31:0]               prdata_q;
    epc_irq_s                  irq_q;
    epc_irq_s                  irq_d;
    logic                      cpulse_q;
    logic                      dpulse_q;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire logic        acc      = psel & penable;
    wire logic        wr       = acc & pwrite;
    wire logic        setup_rd = psel & ~penable & ~pwrite;
    wire logic        sel_ctrl = paddr == EPC_OFF_CTRL;
    wire logic        sel_wrap = paddr == EPC_OFF_WRAP;
    wire logic        sel_cmp  = paddr == EPC_OFF_CMP;
    wire logic        sel_cnt  = paddr == EPC_OFF_CNT;
    wire logic        sel_cap  = paddr == EPC_OFF_CAP;
    wire logic        mapped   = sel_ctrl | sel_wrap | sel_cmp |
                                 sel_cnt | sel_cap;
    wire logic        wr_ctrl  = wr & sel_ctrl;
    // R4 - soft clear strobe
    wire logic        soft_clr = wr_ctrl & pwdata[EPC_B_CLR];
    // R6 - soft capture strobe
    wire logic        soft_cap = wr_ctrl & pwdata[EPC_B_SCAP];

    wire logic [31:0] ctrl_rd  = {15'h0000, dir_q, 1'b0,
                                  ctrl_q.pulse_divider, 4'h0,
                                  ctrl_q.mode,
                                  ctrl_q.three_phase_select,
                                  ctrl_q.z_edge_select,
                                  ctrl_q.z_trigger_enable,
                                  ctrl_q.compare_enable,
                                  ctrl_q.interrupt_enable,
                                  ctrl_q.run_enable};
    wire logic [31:0] rd_mux   =
        sel_ctrl ? ctrl_rd :
        sel_wrap ? {16'h0000, wrap_q} :
        sel_cmp  ? {8'h00, cmp_q} :
        sel_cnt  ? {8'h00, cnt_q} :
        sel_cap  ? {8'h00, cap_q} : 32'h00000000;

    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata  = prdata_q;

    // ------------------------------------------------------------
    // phase decode
    // ------------------------------------------------------------
    wire epc_mode_e   mode   = ctrl_q.mode;
    wire logic        run    = ctrl_q.run_enable;
    wire logic        sensor = (mode == EPC_MODE_SEV) |
                               (mode == EPC_MODE_STM);
    // R19 - three inputs only when software says so
    wire logic        six    = ctrl_q.three_phase_select & sensor;
    wire logic [2:0]  new_i  = six ? hall_idx(sync2_q)
                                   : quad_idx(sync2_q[2:1]);
    wire logic [2:0]  old_i  = six ? hall_idx(prev_q)
                                   : quad_idx(prev_q[2:1]);
    wire logic        valid  = (new_i != 3'h7) & (old_i != 3'h7) &
                               (mode != EPC_MODE_TMR) & run;
    wire logic        cw     = valid & (new_i == step_fwd(old_i, six));
    wire logic        ccw    = valid & (new_i == step_back(old_i, six));
    wire logic        pulse  = cw | ccw;
    wire logic        z_rise = sync2_q[0] & ~prev_q[0];
    wire logic        z_fall = ~sync2_q[0] & prev_q[0];
    // R1 - z used only when trigger enabled
    wire logic        z_enc  = (mode == EPC_MODE_ENC) &
                               (dir_q ? z_rise : z_fall);
    // R2 - timer edge picked by edge select
    wire logic        z_tmr  = (mode == EPC_MODE_TMR) &
                               (ctrl_q.z_edge_select ? z_fall : z_rise);
    wire logic        z_trig = run & ctrl_q.z_trigger_enable &
                               (z_enc | z_tmr);

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    wire logic [EPC_CNT_W-1:0] wrap24 = {8'h00, wrap_q};
    wire logic [EPC_CNT_W-1:0] inc    = 24'(cnt_q + 24'h000001);
    wire logic [EPC_CNT_W-1:0] dec    = 24'(cnt_q - 24'h000001);
    wire logic                 match  = cnt_q == cmp_q;

    // R20 - one shared counter for all modes
    always_comb
    begin
        cnt_d = cnt_q;
        // R4 - soft clear wins in every mode
        if (soft_clr)
            cnt_d = EPC_RST_CNT;
        // R14 - hold while stopped
        else if (run)
        begin
            unique case (mode)
                // R10 - encoder wrap, reload, z clear
                EPC_MODE_ENC:
                    if (z_trig)
                        cnt_d = EPC_RST_CNT;
                    else if (cw)
                        cnt_d = (cnt_q == wrap24) ? EPC_RST_CNT : inc;
                    else if (ccw)
                        cnt_d = (cnt_q == EPC_RST_CNT) ? wrap24 : dec;
                // R11 - sixteen bit event counting
                EPC_MODE_SEV:
                    if (cw)
                        cnt_d = (cnt_q == EPC_MAX16) ? EPC_RST_CNT : inc;
                    else if (ccw)
                        cnt_d = (cnt_q == EPC_RST_CNT) ? EPC_MAX16 : dec;
                // R12 - interval timing, pulse clears
                EPC_MODE_STM:
                    if (pulse || cnt_q == EPC_MAX24)
                        cnt_d = EPC_RST_CNT;
                    else
                        cnt_d = inc;
                // R3 - wrap after max
                // R13 - timer clear conditions
                EPC_MODE_TMR:
                    if (z_trig || match || cnt_q == EPC_MAX24)
                        cnt_d = EPC_RST_CNT;
                    else
                        cnt_d = inc;
            endcase
        end
    end

    // ------------------------------------------------------------
    // capture, direction, divider, interrupts
    // ------------------------------------------------------------
    // R5 - timer z capture
    // R17 - sensor timer pulse capture
    // R18 - external trigger capture
    wire logic cap_ev = soft_cap |
                        (run & (mode == EPC_MODE_STM) & pulse) |
                        (z_trig & (mode == EPC_MODE_TMR));

    // R7 - direction tracks rotation
    assign dir_d = ~run ? 1'b0 :
                   cw   ? 1'b1 :
                   ccw  ? 1'b0 : dir_q;

    wire logic [EPC_DIVCNT_W-1:0] div_lim =
        7'((8'h01 << ctrl_q.pulse_divider) - 8'h01);
    wire logic div_tick = pulse & (div_cnt_q >= div_lim);
    assign div_cnt_d = div_tick ? 7'h00 :
                       pulse    ? 7'(div_cnt_q + 7'h01) : div_cnt_q;

    wire logic match_rise = match & ~match_q & ctrl_q.compare_enable;
    wire logic ien        = ctrl_q.interrupt_enable;

    // R15 - four sources
    // R16 - gated by interrupt enable
    // R8 - compare match interrupt
    // R21 - one cycle per event
    assign irq_d = '{
        event_pulse:   ien & div_tick,
        abnormal_time: ien & match_rise & (mode == EPC_MODE_STM),
        timer_compare: ien & match_rise & (mode != EPC_MODE_STM),
        capture:       ien & cap_ev
    };

    assign irq                    = irq_q;
    assign direction_flag         = dir_q;
    assign quadrature_count_pulse = cpulse_q;
    assign divided_pulse          = dpulse_q;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q   <= EPC_RST_CTRL;
            wrap_q   <= EPC_RST_WRAP;
            cmp_q    <= EPC_RST_CMP;
            prdata_q <= 32'h00000000;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= '{
                    run_enable:         pwdata[EPC_B_RUN],
                    interrupt_enable:   pwdata[EPC_B_INTERRUPT_ENABLE],
                    compare_enable:     pwdata[EPC_B_COMPARE_ENABLE],
                    z_trigger_enable:   pwdata[EPC_B_ZEN],
                    z_edge_select:      pwdata[EPC_B_ZSEL],
                    three_phase_select: pwdata[EPC_B_P3],
                    mode:  epc_mode_e'(pwdata[EPC_B_MODE +: 2]),
                    pulse_divider: pwdata[EPC_B_DIV +: EPC_DIV_W]
                };
            if (wr & sel_wrap)
                wrap_q <= pwdata[EPC_WRAP_W-1:0];
            if (wr & sel_cmp)
                cmp_q <= pwdata[EPC_CNT_W-1:0];
            if (setup_rd)
                prdata_q <= rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            prev_q  <= 3'h0;
        end
        else
        begin
            sync1_q <= {phase_a, phase_b, phase_z};
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q     <= EPC_RST_CNT;
            dir_q     <= 1'b0;
            match_q   <= 1'b0;
            div_cnt_q <= 7'h00;
            irq_q     <= '0;
            cpulse_q  <= 1'b0;
            dpulse_q  <= 1'b0;
        end
        else
        begin
            cnt_q     <= cnt_d;
            dir_q     <= dir_d;
            match_q   <= match;
            div_cnt_q <= div_cnt_d;
            irq_q     <= irq_d;
            cpulse_q  <= pulse;
            dpulse_q  <= div_tick;
        end
    end

    // R9 - only reset clears the capture
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cap_q <= EPC_RST_CNT;
        else if (cap_ev)
            cap_q <= cnt_q;
    end

endmodule

/* bench/epc_sva.sv */
`timescale 1ns/1ps
module epc_sva
    import epc_pkg::*;
(
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [EPC_ADDR_W-1:0] paddr,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic                  phase_a,
    input wire logic                  phase_b,
    input wire logic                  phase_z,
    input wire epc_pkg::epc_irq_s     irq,
    input wire logic                  direction_flag,
    input wire logic                  quadrature_count_pulse
);
    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic       unmapped = !(paddr inside {EPC_OFF_CTRL, EPC_OFF_WRAP,
                                  EPC_OFF_CMP, EPC_OFF_CNT, EPC_OFF_CAP});
    wire logic [2:0] ph = {phase_a, phase_b, phase_z};
    wire logic [1:0] ab = {phase_a, phase_b};
    function automatic logic cw_of(logic [1:0] o, logic [1:0] n);
        return n == {~o[0], o[1]};
    endfunction
    sequence s_rd_unmapped;
        psel && !penable && !pwrite && unmapped;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_ready; pready; endproperty
    property p_err_map; s_access |-> pslverr == unmapped; endproperty
    property p_err_phase; pslverr |-> psel && penable; endproperty
    property p_rd_unmapped;
        s_rd_unmapped ##1 s_access |-> prdata == 32'h0;
    endproperty
    property p_step_age;
        quadrature_count_pulse |-> $past(ph, 3) != $past(ph, 4);
    endproperty
    property p_dir;
        quadrature_count_pulse && $past(ab, 3) != $past(ab, 4)
            |-> direction_flag == cw_of($past(ab, 4), $past(ab, 3));
    endproperty
    property p_event_step; irq.event_pulse |-> quadrature_count_pulse;
    endproperty
    property p_step_once;
        quadrature_count_pulse |=> !quadrature_count_pulse;
    endproperty
    property p_cmp_once;
        irq.timer_compare || irq.abnormal_time
            |=> !(irq.timer_compare || irq.abnormal_time);
    endproperty
    a_ready: assert property (p_ready)
        else $error("pready low");
    a_err_map: assert property (p_err_map)
        else $error("pslverr map");
    a_err_phase: assert property (p_err_phase)
        else $error("pslverr phase");
    a_rd_unmapped: assert property (p_rd_unmapped)
        else $error("unmapped rdata");
    a_step_age: assert property (p_step_age)
        else $error("step no change");
    a_dir: assert property (p_dir)
        else $error("bad direction");
    a_event_step: assert property (p_event_step)
        else $error("event no step");
    a_step_once: assert property (p_step_once)
        else $error("long step");
    a_cmp_once: assert property (p_cmp_once)
        else $error("long compare irq");
endmodule

/* bench/epc_enc_model.sv */
`timescale 1ns/1ps
module epc_enc_model
(
    input  wire logic pclk,
    output logic      phase_a,
    output logic      phase_b,
    output logic      phase_z
);
    // ------------------------------------------------------------
    // quadrature and hall position tables
    // ------------------------------------------------------------
    logic [1:0] quad [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
    logic [2:0] hall [6] = '{3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5};
    logic       three;
    int         pos;
    initial
    begin
        {phase_a, phase_b, phase_z, three} = '0;
        pos = 0;
    end
    task automatic put();
        if (three)
            {phase_a, phase_b, phase_z} <= hall[pos];
        else
            {phase_a, phase_b} <= quad[pos];
    endtask
    // one decoded step, held for hold cycles
    task automatic step(input logic cw, input int hold);
        int n;
        n = three ? 6 : 4;
        @(posedge pclk);
        pos = cw ? (pos + 1) % n : (pos + n - 1) % n;
        put();
        repeat (hold - 1) @(posedge pclk);
    endtask
    task automatic set_z(input logic v);
        @(posedge pclk);
        phase_z <= v;
    endtask
    task automatic set_three(input logic v);
        @(posedge pclk);
        three = v;
        pos = 0;
        put();
    endtask
endmodule

/* bench/tb_encoder_position_counter.sv */
`timescale 1ns/1ps
module tb_encoder_position_counter;
    import epc_pkg::*;
    localparam logic [5:0] F_RUN = 6'h01, F_INT = 6'h02, F_CMP = 6'h04;
    localparam logic [5:0] F_ZEN = 6'h08, F_ZSEL = 6'h10, F_P3 = 6'h20;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [EPC_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd, v, capv;
    logic phase_a, phase_b, phase_z, direction_flag;
    logic quadrature_count_pulse, divided_pulse;
    epc_irq_s irq;
    int errors, compares, exp, wrap, h, n, c;
    epc_top u_dut (.*);
    epc_enc_model u_enc (.*);
    // ------------------------------------------------------------
    // checks and bus tasks
    // ------------------------------------------------------------
    task automatic summarize();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_rng(input logic [31:0] g, input int lo, input int hi);
        compares++;
        if ((g >= 32'(lo) && g <= 32'(hi)) !== 1'b1)
        begin
            errors++;
            $display("mismatch t=%0t got %h range", $time, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
            @(posedge pclk);
        while (++k < 50 && pready !== 1'b1);
        if (k >= 50)
        begin
            errors++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] ctl(input logic [1:0] m,
                                        input logic [5:0] f,
                                        input logic [1:0] cc);
        return (32'(m) << EPC_B_MODE) | (32'(f) << EPC_B_RUN)
             | (32'(cc) << EPC_B_CLR);
    endfunction
    task automatic wait_cmp(output int k);
        k = 0;
        do
            @(negedge pclk);
        while (++k < 500 && irq.timer_compare !== 1'b1);
        if (k >= 500)
        begin
            errors++;
            summarize();
        end
    endtask
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        errors = 0;
        compares = 0;
        n = $urandom(22021);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        for (int i = 0; i < 5; i++)
        begin
            apb(0, 8'(4 * i), 0);
            chk(rd, 32'h0);
        end
        apb(1, 8'h14, 32'hffffffff);
        chk(32'(err), 32'h1);
        apb(0, 8'h14, 0);
        chk({rd[31:1], err}, 32'h1);
        apb(1, EPC_OFF_CNT, 32'h00001234);
        apb(0, EPC_OFF_CNT, 0);
        chk(rd, 32'h0);
        wrap = 3 + $urandom % 6;
        apb(1, EPC_OFF_WRAP, 32'(wrap));
        apb(1, EPC_OFF_CTRL, ctl(EPC_MODE_ENC, F_RUN | F_INT, 0));
        exp = 0;
        for (int i = 0; i < 3 * wrap + 6; i++)
        begin
            u_enc.step(i < 2 * wrap + 3, 4 + $urandom % 3);
            if (i < 2 * wrap + 3)
                exp = (exp == wrap) ? 0 : exp + 1;
            else
                exp = (exp == 0) ? wrap : exp - 1;
            apb(0, EPC_OFF_CNT, 0);
            chk(rd, 32'(exp));
            chk(32'(direction_flag), 32'(i < 2 * wrap + 3));
        end
        apb(1, EPC_OFF_CTRL, ctl(EPC_MODE_ENC, 0, 0));
        u_enc.step(1, 5);
        u_enc.step(1, 5);
        apb(0, EPC_OFF_CNT, 0);
        chk(rd, 32'(exp));
        chk(32'(direction_flag), 32'h0);
        apb(1, EPC_OFF_CTRL, ctl(EPC_MODE_ENC, F_RUN, 0));
        u_enc.step(1, 5);
        exp = (exp == wrap) ? 0 : exp + 1;
        apb(0, EPC_OFF_CNT, 0);
        chk(rd, 32'(exp));
        apb(1, EPC_OFF_CTRL, ctl(EPC_MODE_ENC, F_RUN, 2'h1));
        apb(0, EPC_OFF_CNT, 0);
        chk(rd, 32'h0);
        apb(1, EPC_OFF_CTRL, ctl(EPC_MODE_SEV, F_P3, 0));
        u_enc.set_three(1);
        apb(1, EPC_OFF_CTRL, ctl(EPC_MODE_SEV, F_RUN | F_P3, 2'h1));
        exp = 0;
        for (int i = 0; i < 8; i++)
        begin
            u_enc.step(i != 0, 4 + $urandom % 3);
            exp = (i == 0) ? 32'hffff : (exp + 1) % 32'h10000;
            apb(0, EPC_OFF_CNT, 0);
            chk(rd, 32'(exp));
        end
        apb(1, EPC_OFF_CTRL, ctl(EPC_MODE_STM, F_RUN | F_P3 | F_INT, 0));
        for (int i = 0; i < 3; i++)
        begin
            h = 12 + $urandom % 20;
            u_enc.step(1, h);
            u_enc.step(1, 4);
            apb(0, EPC_OFF_CAP, 0);
            chk_rng(rd, h - 2, h + 1);
            apb(0, EPC_OFF_CNT, 0);
            chk_rng(rd, 0, 12);
        end
        apb(1, EPC_OFF_CMP, 32'h00ffffff);
        apb(1, EPC_OFF_CTRL, ctl(EPC_MODE_TMR, F_RUN, 2'h1));
        u_enc.set_three(0);
        u_enc.set_z(0);
        repeat (30) @(posedge pclk);
        apb(1, EPC_OFF_CTRL, ctl(EPC_MODE_TMR, 0, 0));
        apb(0, EPC_OFF_CNT, 0);
        v = rd;
        chk_rng(v, 25, 60);
        repeat (10) @(posedge pclk);
        apb(0, EPC_OFF_CNT, 0);
        chk(rd, v);
        apb(1, EPC_OFF_CTRL, ctl(EPC_MODE_TMR, 0, 2'h2));
        apb(0, EPC_OFF_CAP, 0);
        chk(rd, v);
        apb(1, EPC_OFF_CTRL, ctl(EPC_MODE_TMR, F_RUN, 0));
        apb(1, EPC_OFF_CTRL, ctl(EPC_MODE_TMR, 0, 0));
        apb(0, EPC_OFF_CAP, 0);
        chk(rd, v);
        capv = v;
        for (int k = 0; k < 3; k++)
        begin
            c = (k < 2) ? F_ZEN : 0;
            c = c | ((k == 1) ? F_ZSEL : 0);
            apb(1, EPC_OFF_CTRL, ctl(EPC_MODE_TMR, 6'(c), 2'h1));
            apb(1, EPC_OFF_CTRL, ctl(EPC_MODE_TMR, 6'(c) | F_RUN, 0));
            repeat (40) @(posedge pclk);
            u_enc.set_z(k != 1);
            repeat (10) @(posedge pclk);
            apb(1, EPC_OFF_CTRL, ctl(EPC_MODE_TMR, 6'(c), 0));
            apb(0, EPC_OFF_CNT, 0);
            if (k < 2)
                chk_rng(rd, 0, 30);
            else
                chk_rng(rd, 50, 200);
            apb(0, EPC_OFF_CAP, 0);
            if (k < 2)
                chk_rng(rd, 40, 100);
            else
                chk(rd, capv);
            capv = rd;
        end
        c = 10 + $urandom % 30;
        apb(1, EPC_OFF_CMP, 32'(c));
        apb(1, EPC_OFF_CTRL,
            ctl(EPC_MODE_TMR, F_RUN | F_INT | F_CMP, 2'h1));
        wait_cmp(n);
        wait_cmp(n);
        chk(32'(n), 32'(c + 1));
        apb(1, EPC_OFF_CTRL, ctl(EPC_MODE_TMR, F_RUN | F_CMP, 2'h1));
        n = 0;
        repeat (3 * c)
        begin
            @(negedge pclk);
            n += (irq.timer_compare === 1'b1);
        end
        chk(32'(n), 32'h0);
        summarize();
    end
endmodule
bind epc_top epc_sva u_sva (.*);
